// File: rtl/mtp_consts.vh
// Purpose: shared constants of the motion tracking and power control block
// Assumes: 40 MHz system clock, 8-bit register address, 16-bit register data
// Notes:   definitions only, no logic
`ifndef MTP_CONSTS_VH
`define MTP_CONSTS_VH

// register offsets
`define MTP_A_CTRL      8'h00
`define MTP_A_RES_X     8'h01
`define MTP_A_RES_Y     8'h02
`define MTP_A_RES_BOTH  8'h03
`define MTP_A_MOT_X     8'h04
`define MTP_A_MOT_Y     8'h05
`define MTP_A_MOT_NZ    8'h06
`define MTP_A_LIFT_CFG  8'h07
`define MTP_A_LIFT_EST  8'h08
`define MTP_A_FORCE     8'h09
`define MTP_A_IDLE_DLY  8'h0a
`define MTP_A_STATE     8'h0b
`define MTP_A_INT_STAT  8'h0c
`define MTP_A_INT_MASK  8'h0d
// sleep table: 0x10 + 2*level is the period, +1 the repeat count
`define MTP_A_SLP_BASE  8'h10
`define MTP_A_SLP_MASK  8'hf8

// field positions
`define MTP_CTRL_RUN    0
`define MTP_LIFT_CUT    2:0
`define MTP_LIFT_HYS    6:4
`define MTP_FORCE_IDX   2:0
`define MTP_FORCE_SLP   4
`define MTP_INT_SLEEP   0
`define MTP_INT_TRANS   1
`define MTP_INT_LIFT    2

// reset values
`define MTP_RST_RES     16'h0320
`define MTP_RST_CUT     3'h7
`define MTP_RST_HYS     3'h0
`define MTP_RST_IDLE    16'h03e8

// mode encodings: bit 3 set marks a sleep mode
`define MTP_ST_TRACK0   4'h0
`define MTP_ST_TRACKMAX 4'h5
`define MTP_ST_SLEEP0   4'h8
`define MTP_ST_SLEEPMAX 4'hb
`define MTP_ST_SLPBIT   3

// timing
`define MTP_CLK_HZ      40000000
`define MTP_MS_PER_S    1000
`define MTP_SAMPLE_BASE 16000

`endif

// File: rtl/mtp_sleep_mem.v
// Purpose: sleep-mode table, one word per sleep level (period low, repeats high)
// Assumes: single clock, writes land per 16-bit half
// Notes:   read data come out of a register, one cycle after the address
module mtp_sleep_mem #(
    parameter DW    = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire          clk,
    input  wire [1:0]    wr_half,   // per-half write enables
    input  wire [AW-1:0] wr_addr,   // entry written
    input  wire [DW-1:0] wr_data,   // data, placed in both halves
    input  wire [AW-1:0] rd_addr,   // entry read
    output reg  [DW-1:0] rd_data    // registered read data
);
    localparam HW = DW / 2;

    wire [DW-1:0] rd_word;          // word at the read address, before the register

    // each half is its own array with its own write enable, so one process writes each array
    genvar h;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_half
            reg [HW-1:0] mem [0:DEPTH-1];   // half-word storage
            always @(posedge clk) begin
                if (wr_half[h]) begin
                    mem[wr_addr] <= wr_data[h*HW +: HW];
                end
            end
            assign rd_word[h*HW +: HW] = mem[rd_addr];
        end
    endgenerate

    // registered read port
    always @(posedge clk) begin
        rd_data <= rd_word;
    end
endmodule // mtp_sleep_mem

// File: rtl/mtp_motion_power.v
// Purpose: motion count, lift detection and track/sleep power sequencing
// Assumes: all inputs synchronous to clk; register reads answer one cycle later
// Notes:   sleep table lives in mtp_sleep_mem, one registered read per level
// Functional notes
// - separate X and Y resolution, 16-bit DPI
// - combined readback gives X value
// - accumulate signed XY counts, clear on read
// - report whether read counts were non-zero
// - lift cutoff 0-7 suppresses tracking output
// - lift hysteresis 0 up to cutoff
// - readable lift estimate, 0 to 7
// - forced sleep index 0-3 enters immediately
// - forced track index 0-5 enters immediately
// - higher track mode samples faster
// - sleep 0 shallowest, sleep 3 deepest
// - per-level 16-bit sleep period in ms
// - per-level repeat count, then deeper sleep
// - idle delay moves track 0 to sleep 0
// - sleep interrupt gated by enable bit
// - state byte: current high, previous low
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "mtp_consts.vh"
module mtp_motion_power #(
    parameter CYC_PER_MS  = `MTP_CLK_HZ / `MTP_MS_PER_S, // clock cycles per millisecond
    parameter SAMPLE_BASE = `MTP_SAMPLE_BASE,            // sample period of track mode 0
    parameter MW          = 8                            // motion delta width
) (
    input  wire                 clk,
    input  wire                 rst_n,
    input  wire [7:0]           reg_addr,
    input  wire [15:0]          reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [15:0]          reg_rdata,
    input  wire                 motion_valid,
    input  wire signed [MW-1:0] motion_dx,
    input  wire signed [MW-1:0] motion_dy,
    input  wire [2:0]           lift_estimate,
    output wire                 track_output_en,
    output wire                 sample_tick,
    output wire [2:0]           track_level_index,
    output wire [1:0]           sleep_level_index,
    output wire                 in_sleep,
    output wire                 irq
);
    // register file state
    reg         run_r;             // tracking engine started
    reg  [15:0] res_x_r;           // x resolution, dpi
    reg  [15:0] res_y_r;           // y resolution, dpi
    reg  [2:0]  cut_r;             // lift cutoff level
    reg  [2:0]  hys_r;             // lift hysteresis
    reg  [15:0] idle_dly_r;        // idle delay in ms
    reg  [2:0]  int_stat_r;        // sticky events
    reg  [2:0]  int_mask_r;        // event enables
    reg  [15:0] mot_x_r;           // x accumulator
    reg  [15:0] mot_y_r;           // y accumulator
    reg  [15:0] mot_y_snap_r;      // y captured when x is read
    reg         mot_nz_r;          // last read pair was non-zero
    reg         lifted_r;          // lift cut in force
    reg  [3:0]  state_r;           // current track/sleep state
    reg  [3:0]  prev_r;            // previous track/sleep state
    reg  [15:0] div_r;             // millisecond divider
    reg  [15:0] ms_r;              // ms spent in current wait
    reg  [15:0] rep_r;             // sleep periods spent
    reg         seen_r;            // motion seen in this sleep period
    reg  [15:0] smp_r;             // sample period counter

    // next values and helpers
    reg  [15:0] rdata_nxt;
    reg  [3:0]  state_nxt;
    reg         restart;           // timing restarts this cycle
    wire        ms_tick;           // one-cycle pulse each ms
    wire        is_sleep;
    wire        motion;            // usable non-zero motion sample
    wire        rd_mot_x;
    wire        wr_force;
    wire [2:0]  ev_set;            // events raised this cycle
    wire [2:0]  ev_clr;            // write-one-to-clear bits
    wire [2:0]  hys_eff;           // hysteresis clamped to cutoff
    wire [2:0]  low_mark;          // level to release lift
    wire        lifted_nxt;
    wire [31:0] slp_word;          // period (low) and repeats (high)
    wire [15:0] smp_period;
    wire [15:0] mot_x_sum;
    wire [15:0] mot_y_sum;
    wire [1:0]  slp_wr_half;

    assign is_sleep  = state_r[`MTP_ST_SLPBIT];
    assign in_sleep  = is_sleep;
    assign track_level_index = is_sleep ? 3'h0 : state_r[2:0];
    assign sleep_level_index = is_sleep ? state_r[1:0] : 2'h0;
    assign rd_mot_x  = reg_rd && (reg_addr == `MTP_A_MOT_X);
    assign wr_force  = reg_wr && (reg_addr == `MTP_A_FORCE);
    assign motion    = motion_valid && !lifted_r && ((motion_dx != 0) || (motion_dy != 0));
    assign track_output_en = !lifted_r;

    // sleep table writes: low half is the period, high half the repeat count
    assign slp_wr_half = (reg_wr && ((reg_addr & `MTP_A_SLP_MASK) == `MTP_A_SLP_BASE)) ?
                         (reg_addr[0] ? 2'h2 : 2'h1) : 2'h0;

    mtp_sleep_mem #(
        .DW    (32),
        .DEPTH (4),
        .AW    (2)
    ) u_sleep_mem (
        .clk     (clk),
        .wr_half (slp_wr_half),
        .wr_addr (reg_addr[2:1]),
        .wr_data ({reg_wdata, reg_wdata}),
        .rd_addr (state_r[1:0]),
        .rd_data (slp_word)
    );

    // lift hysteresis never goes past the cutoff
    assign hys_eff   = (hys_r > cut_r) ? cut_r : hys_r;
    assign low_mark  = cut_r - hys_eff;
    // lift sets above cutoff and releases at or below cutoff minus hysteresis
    assign lifted_nxt = lifted_r ? (lift_estimate > low_mark) : (lift_estimate > cut_r);

    // sign-extended accumulation of the new deltas
    assign mot_x_sum = (rd_mot_x ? 16'h0000 : mot_x_r) + {{(16-MW){motion_dx[MW-1]}}, motion_dx};
    assign mot_y_sum = (rd_mot_x ? 16'h0000 : mot_y_r) + {{(16-MW){motion_dy[MW-1]}}, motion_dy};

    // lift detection state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lifted_r <= 1'b0;
        end else begin
            lifted_r <= lifted_nxt;
        end
    end

    // motion accumulators; a read clears them but keeps a sample arriving with it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mot_x_r      <= 16'h0000;
            mot_y_r      <= 16'h0000;
            mot_y_snap_r <= 16'h0000;
            mot_nz_r     <= 1'b0;
        end else begin
            if (rd_mot_x) begin
                mot_y_snap_r <= mot_y_r;
                mot_nz_r     <= (mot_x_r != 16'h0000) || (mot_y_r != 16'h0000);
            end
            if (motion) begin
                mot_x_r <= mot_x_sum;
                mot_y_r <= mot_y_sum;
            end else if (rd_mot_x) begin
                mot_x_r <= 16'h0000;
                mot_y_r <= 16'h0000;
            end
        end
    end

    // millisecond enable from the system clock
    assign ms_tick = (div_r == CYC_PER_MS[15:0] - 16'h0001);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 16'h0000;
        end else if (ms_tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // sample period halves with each track level up
    assign smp_period = SAMPLE_BASE[15:0] >> state_r[2:0];
    assign sample_tick = run_r && !is_sleep && (smp_r == 16'h0000);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_r <= 16'h0000;
        end else if (!run_r || is_sleep || (smp_r == 16'h0000)) begin
            smp_r <= smp_period - 16'h0001;
        end else begin
            smp_r <= smp_r - 16'h0001;
        end
    end

    // track/sleep sequencer: next state and timing restart
    always @* begin
        state_nxt = state_r;
        restart   = 1'b0;
        if (!run_r) begin
            // engine stopped: parked in track 0
            state_nxt = `MTP_ST_TRACK0;
            restart   = 1'b1;
        end else if (wr_force) begin
            restart = 1'b1;
            if (reg_wdata[`MTP_FORCE_SLP]) begin
                // forced sleep, index limited to 0..3
                state_nxt = {2'h2, reg_wdata[1:0]};
            end else if (reg_wdata[`MTP_FORCE_IDX] <= `MTP_ST_TRACKMAX) begin
                // forced track, index 0..5; larger indices ignored
                state_nxt = {1'b0, reg_wdata[`MTP_FORCE_IDX]};
            end
        end else if (!is_sleep) begin
            if (motion) begin
                // motion keeps the idle timer fresh
                restart = 1'b1;
            end else if (ms_tick && (ms_r >= idle_dly_r)) begin
                restart = 1'b1;
                if (state_r == `MTP_ST_TRACK0) begin
                    state_nxt = `MTP_ST_SLEEP0;
                end else begin
                    state_nxt = state_r - 4'h1;
                end
            end
        end else if (ms_tick && (ms_r + 16'h0001 >= slp_word[15:0])) begin
            // end of one sleep period: check for motion
            restart = 1'b1;
            if (seen_r || motion) begin
                state_nxt = `MTP_ST_TRACK0;
            end else if ((rep_r + 16'h0001 >= slp_word[31:16]) && (state_r != `MTP_ST_SLEEPMAX)) begin
                state_nxt = state_r + 4'h1;
            end
        end
    end

    // sequencer registers and timers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `MTP_ST_TRACK0;
            prev_r  <= `MTP_ST_TRACK0;
            ms_r    <= 16'h0000;
            rep_r   <= 16'h0000;
            seen_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                prev_r <= state_r;
            end
            // idle or period timing, saturating
            if (restart) begin
                ms_r <= 16'h0000;
            end else if (ms_tick && (ms_r != 16'hffff)) begin
                ms_r <= ms_r + 16'h0001;
            end
            // repeat count of the current sleep level
            if (state_nxt != state_r) begin
                rep_r <= 16'h0000;
            end else if (is_sleep && restart && (rep_r != 16'hffff)) begin
                rep_r <= (rep_r + 16'h0001 >= slp_word[31:16]) ? 16'h0000 : rep_r + 16'h0001;
            end
            // motion noticed during a sleep period
            if (restart) begin
                seen_r <= 1'b0;
            end else if (motion) begin
                seen_r <= 1'b1;
            end
        end
    end

    // interrupt events
    assign ev_set[`MTP_INT_SLEEP] = run_r && (state_nxt != state_r) && state_nxt[`MTP_ST_SLPBIT]
                                    && !is_sleep;
    assign ev_set[`MTP_INT_TRANS] = run_r && (state_nxt != state_r);
    assign ev_set[`MTP_INT_LIFT]  = (lifted_nxt != lifted_r);
    assign ev_clr = (reg_wr && (reg_addr == `MTP_A_INT_STAT)) ? reg_wdata[2:0] : 3'h0;
    // one level output while any enabled status bit is set
    assign irq = |(int_stat_r & int_mask_r);

    // software-written registers and sticky status; a set beats a clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r      <= 1'b0;
            res_x_r    <= `MTP_RST_RES;
            res_y_r    <= `MTP_RST_RES;
            cut_r      <= `MTP_RST_CUT;
            hys_r      <= `MTP_RST_HYS;
            idle_dly_r <= `MTP_RST_IDLE;
            int_mask_r <= 3'h0;
            int_stat_r <= 3'h0;
        end else begin
            int_stat_r <= (int_stat_r & ~ev_clr) | ev_set;
            if (reg_wr) begin
                case (reg_addr)
                    `MTP_A_CTRL: begin
                        run_r <= reg_wdata[`MTP_CTRL_RUN];
                    end
                    `MTP_A_RES_X: begin
                        res_x_r <= reg_wdata;
                    end
                    `MTP_A_RES_Y: begin
                        res_y_r <= reg_wdata;
                    end
                    `MTP_A_LIFT_CFG: begin
                        cut_r <= reg_wdata[`MTP_LIFT_CUT];
                        hys_r <= reg_wdata[`MTP_LIFT_HYS];
                    end
                    `MTP_A_IDLE_DLY: begin
                        idle_dly_r <= reg_wdata;
                    end
                    `MTP_A_INT_MASK: begin
                        int_mask_r <= reg_wdata[2:0];
                    end
                    default: begin
                        // other offsets have no stored field here
                    end
                endcase
            end
        end
    end

    // read data mux
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `MTP_A_CTRL:     rdata_nxt = {15'h0000, run_r};
            `MTP_A_RES_X:    rdata_nxt = res_x_r;
            `MTP_A_RES_Y:    rdata_nxt = res_y_r;
            `MTP_A_RES_BOTH: rdata_nxt = (res_x_r == res_y_r) ? res_y_r : res_x_r;
            `MTP_A_MOT_X:    rdata_nxt = mot_x_r;
            `MTP_A_MOT_Y:    rdata_nxt = mot_y_snap_r;
            `MTP_A_MOT_NZ:   rdata_nxt = {15'h0000, mot_nz_r};
            `MTP_A_LIFT_CFG: rdata_nxt = {9'h000, hys_r, 1'b0, cut_r};
            `MTP_A_LIFT_EST: rdata_nxt = {12'h000, lifted_r, lift_estimate};
            `MTP_A_IDLE_DLY: rdata_nxt = idle_dly_r;
            `MTP_A_STATE:    rdata_nxt = {8'h00, state_r, prev_r};
            `MTP_A_INT_STAT: rdata_nxt = {13'h0000, int_stat_r};
            `MTP_A_INT_MASK: rdata_nxt = {13'h0000, int_mask_r};
            default:         rdata_nxt = 16'h0000;
        endcase
    end

    // read data stand in the cycle after the read strobe only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // mtp_motion_power

// File: testbench/mtp_motion_power_sva.sv
// Purpose: port-level checker for mtp_motion_power
// Assumes: one clock, async active-low reset
// Notes:   run bit is shadowed from writes to the control register
`include "mtp_consts.vh"
module mtp_motion_power_sva (
    input logic        clk,
    input logic        rst_n,
    input logic [7:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata,
    input logic [2:0]  lift_estimate,
    input logic        track_output_en,
    input logic        sample_tick,
    input logic [2:0]  track_level_index,
    input logic [1:0]  sleep_level_index,
    input logic        in_sleep,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_r; // shadow of the run bit

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // follow the run bit so force commands can be judged
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
        end else if (reg_wr && reg_addr == `MTP_A_CTRL) begin
            run_r <= reg_wdata[`MTP_CTRL_RUN];
        end
    end

    // force commands, split by kind
    sequence s_frc;
        reg_wr && reg_addr == `MTP_A_FORCE;
    endsequence
    sequence s_frc_slp;
        s_frc ##0 (reg_wdata[4] && run_r);
    endsequence
    sequence s_frc_trk;
        s_frc ##0 (!reg_wdata[4] && reg_wdata[2:0] <= 3'h5 && run_r);
    endsequence

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data not zero outside read cycle");
    a_track_zero_sleep: assert property (in_sleep |-> track_level_index == 3'h0)
        else $error("track level not zero while sleeping");
    a_sleep_zero_track: assert property (!in_sleep |-> sleep_level_index == 2'h0)
        else $error("sleep level not zero while tracking");
    a_tick_quiet: assert property ((in_sleep || (!run_r && !$past(run_r))) |-> !sample_tick)
        else $error("sample tick while asleep or stopped");
    a_tick_one_cycle: assert property (sample_tick |=> !sample_tick)
        else $error("sample tick longer than one cycle");
    a_lift_release: assert property ((lift_estimate == 3'h0) [*3] |-> track_output_en)
        else $error("output blanked at zero lift");
    a_force_sleep_now: assert property (s_frc_slp |=> in_sleep && sleep_level_index == $past(reg_wdata[1:0]))
        else $error("forced sleep not entered");
    a_force_track_now: assert property (s_frc_trk |=> !in_sleep && track_level_index == $past(reg_wdata[2:0]))
        else $error("forced track not entered");
    a_force_stop_ignore: assert property (s_frc ##0 !run_r |=> $stable(in_sleep) && $stable(track_level_index))
        else $error("force acted while stopped");
    a_irq_sticky: assert property (irq && !(reg_wr && reg_addr[7:1] == 7'h06) |=> irq)
        else $error("interrupt dropped without a write");
endmodule // mtp_motion_power_sva

bind mtp_motion_power mtp_motion_power_sva u_mtp_motion_power_sva (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lift_estimate(lift_estimate),
    .track_output_en(track_output_en), .sample_tick(sample_tick), .track_level_index(track_level_index),
    .sleep_level_index(sleep_level_index), .in_sleep(in_sleep), .irq(irq));

// File: testbench/mtp_motion_power_tb.sv
// Purpose: register-level self-checking bench for mtp_motion_power
// Assumes: short ms and sample counts set by parameters
// Notes:   after time 0 all inputs change by non-blocking assignment, at rising edges or 1 ns after them
`include "mtp_consts.vh"
module mtp_motion_power_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam CPM = 4;              // cycles per ms
    localparam SB  = 64;             // track 0 sample period
    logic              clk = 1'b0;
    logic              rst_n, reg_wr, reg_rd, motion_valid, track_output_en, sample_tick, in_sleep, irq;
    logic [7:0]        reg_addr;
    logic [15:0]       reg_wdata, reg_rdata, rd;
    logic signed [7:0] motion_dx, motion_dy;
    logic [2:0]        lift_estimate, track_level_index;
    logic [1:0]        sleep_level_index;
    int                failures = 0, n_tests = 0, cyc = 0, n, k;

    mtp_motion_power #(.CYC_PER_MS(CPM), .SAMPLE_BASE(SB), .MW(8)) u_mtp_motion_power (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motion_valid(motion_valid), .motion_dx(motion_dx),
        .motion_dy(motion_dy), .lift_estimate(lift_estimate), .track_output_en(track_output_en),
        .sample_tick(sample_tick), .track_level_index(track_level_index),
        .sleep_level_index(sleep_level_index), .in_sleep(in_sleep), .irq(irq));

    // clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd16(a, d);
        check(d, exp);
    endtask

    // one motion sample
    task automatic mot(input logic signed [7:0] dx, input logic signed [7:0] dy);
        @(posedge clk);
        motion_valid <= 1'b1; motion_dx <= dx; motion_dy <= dy;
        @(posedge clk);
        motion_valid <= 1'b0;
    endtask

    // state code as in the state byte
    function automatic logic [3:0] st();
        return in_sleep ? {2'b10, sleep_level_index} : {1'b0, track_level_index};
    endfunction

    task automatic wait_st(input logic [3:0] s, input int lim, output int c);
        c = 0;
        #1;
        while (st() !== s && c < lim) begin
            @(posedge clk);
            #1 c++;
        end
    endtask

    // cycles between two sample ticks
    task automatic tick_per(output int c);
        c = 0;
        while (sample_tick !== 1'b1 && c < 200) begin @(posedge clk); #1 c++; end
        c = 0;
        do begin @(posedge clk); #1 c++; end while (sample_tick !== 1'b1 && c < 200);
    endtask

    initial begin
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
        motion_valid = 1'b0; motion_dx = 8'sh00; motion_dy = 8'sh00; lift_estimate = 3'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped and write-only places
        rdc(`MTP_A_RES_X, `MTP_RST_RES);
        rdc(`MTP_A_RES_Y, `MTP_RST_RES);
        rdc(`MTP_A_RES_BOTH, `MTP_RST_RES);
        rdc(`MTP_A_LIFT_CFG, 16'h0007);
        rdc(`MTP_A_IDLE_DLY, 16'h03e8);
        rdc(8'h20, 16'h0000);
        rdc(`MTP_A_SLP_BASE, 16'h0000);
        // resolutions differ: combined gives x
        wr(`MTP_A_RES_X, 16'h0640);
        rdc(`MTP_A_RES_X, 16'h0640);
        rdc(`MTP_A_RES_Y, 16'h0320);
        rdc(`MTP_A_RES_BOTH, 16'h0640);
        // force refused while stopped
        wr(`MTP_A_FORCE, 16'h0012);
        rdc(`MTP_A_STATE, 16'h0000);
        wr(`MTP_A_CTRL, 16'h0001);
        // motion sums clear on read
        mot(8'sd5, -8'sd3);
        mot(-8'sd2, 8'sd0);
        rdc(`MTP_A_MOT_X, 16'h0003);
        rdc(`MTP_A_MOT_Y, 16'hfffd);
        rdc(`MTP_A_MOT_NZ, 16'h0001);
        rdc(`MTP_A_MOT_X, 16'h0000);
        rdc(`MTP_A_MOT_NZ, 16'h0000);
        // lift with cutoff 4, hysteresis 2
        wr(`MTP_A_LIFT_CFG, 16'h0024);
        lift_estimate <= 3'h5;
        repeat (3) @(posedge clk);
        #1 check(16'(track_output_en), 16'h0);
        rdc(`MTP_A_LIFT_EST, 16'h000d);
        lift_estimate <= 3'h3;
        repeat (3) @(posedge clk);
        #1 check(16'(track_output_en), 16'h0);
        lift_estimate <= 3'h2;
        repeat (3) @(posedge clk);
        #1 check(16'(track_output_en), 16'h1);
        rdc(`MTP_A_LIFT_EST, 16'h0002);
        // hysteresis equal to the cutoff, the largest legal setting
        wr(`MTP_A_LIFT_CFG, 16'h0033);
        rdc(`MTP_A_LIFT_CFG, 16'h0033);
        lift_estimate <= 3'h0;
        wr(`MTP_A_LIFT_CFG, 16'h0007);
        // every forced sleep and track level
        for (k = 0; k < 4; k++) begin
            wr(`MTP_A_FORCE, 16'h0010 | 16'(k));
            #1 check(16'(st()), 16'(8 + k));
        end
        for (k = 0; k < 6; k++) begin
            wr(`MTP_A_FORCE, 16'(k));
            #1 check(16'(st()), 16'(k));
            tick_per(n);
            check(16'(n), 16'(SB >> k));
        end
        rdc(`MTP_A_STATE, 16'h0054);
        wr(`MTP_A_FORCE, 16'h0006);
        rdc(`MTP_A_STATE, 16'h0054);
        // sleep table (period k+1 ms, two repeats) and idle 3 ms, written while stopped
        wr(`MTP_A_CTRL, 16'h0000);
        for (k = 0; k < 4; k++) begin
            wr(`MTP_A_SLP_BASE + 8'(2 * k), 16'(k + 1));
            wr(`MTP_A_SLP_BASE + 8'(2 * k + 1), 16'h0002);
        end
        wr(`MTP_A_IDLE_DLY, 16'h0003);
        wr(`MTP_A_INT_STAT, 16'h0007);
        wr(`MTP_A_INT_MASK, 16'h0001);
        #1 check(16'(irq), 16'h0);
        wr(`MTP_A_CTRL, 16'h0001);
        wr(`MTP_A_FORCE, 16'h0000);
        wait_st(4'h8, 40 * CPM, n);
        check(16'(st()), 16'h0008);
        check(16'(n >= 2 * CPM && n <= 5 * CPM), 16'h1);
        wait_st(4'h9, 40 * CPM, n);
        check(16'(st()), 16'h0009);
        wait_st(4'ha, 40 * CPM, n);
        check(16'(st()), 16'h000a);
        check(16'(n >= 3 * CPM && n <= 5 * CPM), 16'h1);
        wait_st(4'hb, 40 * CPM, n);
        check(16'(n >= 5 * CPM && n <= 7 * CPM), 16'h1);
        repeat (30 * CPM) @(posedge clk);
        #1 check(16'(st()), 16'h000b);
        // sleep interrupt: mask, unmask, clear; status holds sleep entry and state change
        check(16'(irq), 16'h1);
        rd16(`MTP_A_INT_STAT, rd);
        check(rd, 16'h0003);
        wr(`MTP_A_INT_MASK, 16'h0000);
        #1 check(16'(irq), 16'h0);
        wr(`MTP_A_INT_MASK, 16'h0001);
        #1 check(16'(irq), 16'h1);
        wr(`MTP_A_INT_STAT, 16'h0001);
        #1 check(16'(irq), 16'h0);
        // motion wakes the deepest sleep
        mot(8'sd4, 8'sd0);
        wait_st(4'h0, 10 * CPM, n);
        check(16'(st()), 16'h0000);
        tally_and_finish();
    end
endmodule // mtp_motion_power_tb
